// ==== shared/fe_pkg.sv ====
/*
 * Shared constants, instruction and micro-op carriers, and helpers for the
 * loop queue / decode front end.
 * Assumes the predecoder fills every field of instr_t before queueing.
 */
package fe_pkg;

	localparam int QUEUE_DEPTH = 18;
	localparam int PD_MAX = 6;
	localparam int DELIVER_MAX = 5;
	localparam int NUM_DEC = 4;
	localparam int COMPLEX_MAX_UOPS = 4;
	localparam int MSEQ_RATE = 3;
	localparam int FUSE_PER_CYCLE = 1;
	localparam int OUT_FIFO_DEPTH = 16;
	localparam int CNT_W = 5;
	localparam int UOPS_W = 5;
	localparam int TAG_W = 16;
	localparam int SP_W = 8;
	localparam logic [UOPS_W-1:0] ONE_UOP = 5'h01;
	localparam logic signed [SP_W-1:0] SP_ZERO = 8'sh00;

	typedef enum logic [3:0] {
		kind_alu,
		kind_cmp,
		kind_jcc,
		kind_push,
		kind_pop,
		kind_call,
		kind_frame_exit_instr,
		kind_subroutine_return_instr,
		kind_other
	} instr_kind_t;

	typedef struct packed {
		instr_kind_t kind;
		logic [UOPS_W-1:0] raw_uops;
		logic micro_fusable;
		logic signed [SP_W-1:0] sp_delta;
		logic sp_explicit;
		logic loop_start;
		logic [CNT_W-1:0] loop_len;
		logic [TAG_W-1:0] tag;
	} instr_t;

	typedef struct packed {
		logic valid;
		instr_kind_t kind;
		logic macro_fused;
		logic micro_fused;
		logic from_mseq;
		logic [2:0] part;
		logic signed [SP_W-1:0] sp_off;
		logic [TAG_W-1:0] tag;
	} uop_t;

	typedef struct packed {
		uop_t [NUM_DEC-1:0] slot;
	} uop_group_t;

	typedef struct packed {
		logic valid;
		instr_t instr;
		logic macro_fused;
		logic from_mseq;
		logic [2:0] part;
		logic signed [SP_W-1:0] sp_off;
	} slot_in_t;

	typedef struct packed {
		logic valid;
		logic [2:0] count;
		instr_t [PD_MAX-1:0] instr;
	} pd_bundle_t;

	// micro-op count after stack tracking and micro-fusion
	function automatic logic [UOPS_W-1:0] eff_uops(input instr_t i);
		if (i.kind == kind_push || i.kind == kind_pop || i.kind == kind_subroutine_return_instr)
			return ONE_UOP;
		else if (i.micro_fusable)
			return ONE_UOP;
		else
			return i.raw_uops;
	endfunction : eff_uops

	function automatic logic is_stack_op(input instr_t i);
		return i.kind inside {kind_push, kind_pop, kind_call, kind_frame_exit_instr,
			kind_subroutine_return_instr};
	endfunction : is_stack_op

endpackage : fe_pkg

// ==== verilog/uop_fifo.sv ====
/*
 * Micro-op bundle FIFO with a registered output stage.
 * Assumes one clock; the drain side may stall at any time.
 */
`timescale 1ns/1ps
`default_nettype none
module uop_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	if (DEPTH < 2 || WIDTH < 1) begin : g_bad
		$error("uop_fifo needs DEPTH >= 2 and WIDTH >= 1");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic vld_q, vld_d;
	logic [WIDTH-1:0] dat_q, dat_d;
	logic push, pop, load;

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction : ptr_inc

	assign in_ready = (cnt_q != CW'(DEPTH));
	assign out_valid = vld_q;
	assign out_data = dat_q;

	always_comb begin
		mem_d = mem_q;
		wr_d = wr_q;
		rd_d = rd_q;
		cnt_d = cnt_q;
		vld_d = vld_q;
		dat_d = dat_q;
		load = !vld_q || out_ready;
		push = in_valid && in_ready;
		pop = load && (cnt_q != '0);
		if (push) begin
			mem_d[wr_q] = in_data;
			wr_d = ptr_inc(wr_q);
		end
		if (pop) begin
			dat_d = mem_q[rd_q];
			rd_d = ptr_inc(rd_q);
		end
		if (load)
			vld_d = pop;
		cnt_d = CW'(cnt_q + CW'(push) - CW'(pop));
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			vld_q <= 1'b0;
			dat_q <= '0;
		end else if (ce) begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
			vld_q <= vld_d;
			dat_q <= dat_d;
		end
	end

	always_ff @(posedge clk) begin
		if (ce)
			mem_q <= mem_d;
	end

	chk_fifo_bound: assert property (@(posedge clk) disable iff (rst)
		cnt_q <= CW'(DEPTH)) else $error("fifo count above depth");
	chk_fifo_hold: assert property (@(posedge clk) disable iff (rst)
		ce && vld_q && !out_ready |=> vld_q && $stable(dat_q))
		else $error("stalled output changed");

endmodule : uop_fifo
`default_nettype wire

// ==== verilog/slot_decoder.sv ====
/*
 * One decoder slot: turns a steered instruction into one micro-op.
 * Assumes the steering logic only hands multi-op flows to the complex slot.
 */
`timescale 1ns/1ps
`default_nettype none
module slot_decoder #(
	parameter bit COMPLEX = 1'b0
) (
	input wire logic clk,
	input wire logic rst,
	input wire fe_pkg::slot_in_t slot_in,
	output fe_pkg::uop_t uop
);
	import fe_pkg::*;

	always_comb begin
		uop = '0;
		uop.valid = slot_in.valid;
		uop.kind = slot_in.instr.kind;
		uop.tag = slot_in.instr.tag;
		uop.macro_fused = slot_in.macro_fused; // RULE_12
		uop.micro_fused = slot_in.instr.micro_fusable; // RULE_17
		uop.from_mseq = slot_in.from_mseq;
		uop.part = slot_in.part;
		// stack update rides along as an offset, no extra op
		uop.sp_off = is_stack_op(slot_in.instr) ? slot_in.sp_off : SP_ZERO; // RULE_15
	end

	chk_simple_single: assert property (@(posedge clk) disable iff (rst) // RULE_10
		!COMPLEX && slot_in.valid && !slot_in.from_mseq && slot_in.part == 3'h0
		|-> eff_uops(slot_in.instr) == ONE_UOP || slot_in.macro_fused)
		else $error("simple decoder got multi-op flow");
	chk_stack_single: assert property (@(posedge clk) disable iff (rst) // RULE_16
		slot_in.valid && slot_in.instr.kind inside {kind_push, kind_pop,
		kind_subroutine_return_instr} |-> slot_in.part == 3'h0 && !slot_in.from_mseq)
		else $error("stack op split into several ops");

endmodule : slot_decoder
`default_nettype wire

// ==== verilog/loop_queue_decode_front_end.sv ====
/*
 * Instruction queue with loop replay, four-slot decoder group, micro-op
 * sequencer, macro-fusion and stack offset tracking; output through a FIFO.
 * Assumes predecoder, mode and mispredict inputs are on clk.
 */
// Contract
// [RULE_01] queue holds at most 18 predecoded instructions
// [RULE_02] no more than five instructions frame_exit_instr the queue per cycle
// [RULE_03] at most one fused pair per cycle
// [RULE_04] replay only loops shorter than 18 instructions
// [RULE_05] detected loop is locked in the queue and replayed
// [RULE_06] replay lasts until a misprediction
// [RULE_07] fetch, predictor and predecode idle during replay
// [RULE_08] replay loses no bandwidth to taken branches or alignment
// [RULE_09] four decoders; first one takes flows up to 4 ops
// [RULE_10] other three decoders take single-op flows only
// [RULE_11] flows above 4 ops go to sequencer, 3 ops per cycle
// [RULE_12] every decoder handles fused and stack-tracked single-op flows
// [RULE_13] macro-fusion merges an adjacent eligible pair into one op
// [RULE_14] macro-fusion only outside 64-bit mode
// [RULE_15] implicit stack pointer updates done by tracker in decoders
// [RULE_16] push, pop and return decode to exactly one op
// [RULE_17] micro-fusion makes one complex op per instruction
// [RULE_18] predecoder writes at most six instructions per cycle
// [RULE_19] misprediction unlocks queue and resumes normal fetch
`timescale 1ns/1ps
`default_nettype none
module loop_queue_decode_front_end #(
	parameter int DEPTH = fe_pkg::QUEUE_DEPTH,
	parameter int FIFO_DEPTH = fe_pkg::OUT_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic mode64,
	input wire fe_pkg::pd_bundle_t pd_in,
	output logic pd_ready,
	input wire logic mispredict,
	output logic redirect,
	output logic fetch_idle,
	output logic replay_active,
	output logic out_valid,
	input wire logic out_ready,
	output fe_pkg::uop_group_t out_group
);
	import fe_pkg::*;

	if (DEPTH < PD_MAX + 1 || DEPTH > 31 || FIFO_DEPTH < 2) begin : g_bad
		$error("queue depth must be 7..31 and fifo depth at least 2");
	end

	typedef enum {st_normal, st_replay} fe_state_t;

	fe_state_t state_q, state_d;
	instr_t mem_q [DEPTH];
	instr_t mem_d [DEPTH];
	logic [CNT_W-1:0] head_q, head_d, count_q, count_d;
	logic [CNT_W-1:0] lock_start_q, lock_start_d, loop_len_q, loop_len_d;
	logic [CNT_W-1:0] rep_pos_q, rep_pos_d;
	logic [UOPS_W-1:0] mseq_left_q, mseq_left_d;
	logic [2:0] mseq_part_q, mseq_part_d;
	instr_t mseq_instr_q, mseq_instr_d;
	logic signed [SP_W-1:0] sp_q, sp_d;
	logic pd_ready_q, pd_ready_d, redirect_q, redirect_d;
	logic fetch_idle_q, fetch_idle_d;

	slot_in_t [NUM_DEC-1:0] slot_in;
	uop_group_t group;
	logic fifo_in_ready, fifo_in_valid, go, lock_now;
	int used, fused_cnt, uop_cnt;
	logic mseq_busy;

	function automatic logic [CNT_W-1:0] q_idx(input logic [CNT_W-1:0] base, input int k);
		int s;
		s = int'(base) + k;
		if (s >= DEPTH)
			s = s - DEPTH;
		return CNT_W'(s);
	endfunction : q_idx

	// position inside a locked loop, wrapping at the loop length
	function automatic logic [CNT_W-1:0] loop_off(input logic [CNT_W-1:0] pos, input int k,
		input logic [CNT_W-1:0] len);
		int s;
		s = int'(pos) + k;
		for (int i = 0; i < DELIVER_MAX + 1; i++) begin
			if (len != '0 && s >= int'(len))
				s = s - int'(len);
		end
		return CNT_W'(s);
	endfunction : loop_off

	function automatic logic avail(input int k);
		if (state_q == st_replay)
			return 1'b1; // RULE_08
		return k < int'(count_q);
	endfunction : avail

	function automatic instr_t rd(input int k);
		if (state_q == st_replay)
			return mem_q[q_idx(lock_start_q, int'(loop_off(rep_pos_q, k, loop_len_q)))];
		return mem_q[q_idx(head_q, k)];
	endfunction : rd

	// loop detector: head marks a loop start whose closing branch is already queued
	always_comb begin
		instr_t h;
		h = mem_q[head_q];
		lock_now = 1'b0;
		if (state_q == st_normal && !mseq_busy && count_q != '0 && h.loop_start
			&& h.loop_len != '0 && int'(h.loop_len) < DEPTH // RULE_04
			&& count_q >= h.loop_len
			&& mem_q[q_idx(head_q, int'(h.loop_len) - 1)].kind == kind_jcc)
			lock_now = 1'b1; // RULE_05
	end

	assign mseq_busy = (mseq_left_q != '0);
	assign go = ce && fifo_in_ready && !lock_now && !mispredict;

	// steering of queued instructions onto the decoder slots
	always_comb begin
		instr_t cur;
		logic stop;
		int slot;
		int e;
		logic signed [SP_W-1:0] sp;
		cur = '0;
		stop = 1'b0;
		slot = 0;
		e = 0;
		sp = sp_q;
		used = 0;
		fused_cnt = 0;
		uop_cnt = 0;
		slot_in = '0;
		mseq_left_d = mseq_left_q;
		mseq_part_d = mseq_part_q;
		mseq_instr_d = mseq_instr_q;
		if (mseq_busy) begin
			for (int j = 0; j < MSEQ_RATE; j++) begin
				if (UOPS_W'(j) < mseq_left_q) begin
					slot_in[j].valid = 1'b1;
					slot_in[j].instr = mseq_instr_q;
					slot_in[j].from_mseq = 1'b1;
					slot_in[j].part = 3'(mseq_part_q + 3'(j));
					uop_cnt = uop_cnt + 1;
				end
			end
			if (mseq_left_q > UOPS_W'(MSEQ_RATE)) begin // RULE_11
				mseq_left_d = UOPS_W'(mseq_left_q - UOPS_W'(MSEQ_RATE));
				mseq_part_d = 3'(mseq_part_q + 3'(MSEQ_RATE));
			end else begin
				mseq_left_d = '0;
			end
		end else begin
			for (int it = 0; it < DELIVER_MAX; it++) begin
				if (!stop && slot < NUM_DEC && used < DELIVER_MAX && avail(used)) begin // RULE_02
					cur = rd(used);
					e = int'(eff_uops(cur)); // RULE_16
					if (fused_cnt < FUSE_PER_CYCLE && !mode64 && cur.kind == kind_cmp // RULE_14
						&& used + 1 < DELIVER_MAX && avail(used + 1)
						&& rd(used + 1).kind == kind_jcc) begin
						slot_in[slot].valid = 1'b1; // RULE_13
						slot_in[slot].instr = rd(used + 1);
						slot_in[slot].macro_fused = 1'b1;
						fused_cnt = fused_cnt + 1; // RULE_03
						slot = slot + 1;
						used = used + 2;
						uop_cnt = uop_cnt + 1;
					end else if (e <= 1) begin
						slot_in[slot].valid = 1'b1;
						slot_in[slot].instr = cur;
						slot_in[slot].sp_off = sp;
						slot = slot + 1;
						used = used + 1;
						uop_cnt = uop_cnt + 1;
					end else if (slot == 0 && e <= COMPLEX_MAX_UOPS) begin
						for (int j = 0; j < COMPLEX_MAX_UOPS; j++) begin
							if (j < e) begin
								slot_in[j].valid = 1'b1; // RULE_09
								slot_in[j].instr = cur;
								slot_in[j].part = 3'(j);
								slot_in[j].sp_off = sp;
								uop_cnt = uop_cnt + 1;
							end
						end
						used = used + 1;
						stop = 1'b1;
					end else if (slot == 0) begin
						for (int j = 0; j < MSEQ_RATE; j++) begin
							slot_in[j].valid = 1'b1; // RULE_11
							slot_in[j].instr = cur;
							slot_in[j].from_mseq = 1'b1;
							slot_in[j].part = 3'(j);
							uop_cnt = uop_cnt + 1;
						end
						mseq_left_d = UOPS_W'(e - MSEQ_RATE);
						mseq_part_d = 3'(MSEQ_RATE);
						mseq_instr_d = cur;
						used = used + 1;
						stop = 1'b1;
					end else begin
						stop = 1'b1; // multi-op flow waits for slot 0 next cycle
					end
					if (e <= COMPLEX_MAX_UOPS || slot == 0) begin
						if (cur.sp_explicit)
							sp = SP_ZERO;
						else if (is_stack_op(cur))
							sp = SP_W'(sp + cur.sp_delta); // RULE_15
					end
				end
			end
		end
		sp_d = go ? sp : sp_q;
		if (!go) begin
			mseq_left_d = mseq_left_q;
			mseq_part_d = mseq_part_q;
			mseq_instr_d = mseq_instr_q;
			used = 0;
		end
	end

	for (genvar g = 0; g < NUM_DEC; g++) begin : g_dec
		slot_decoder #(.COMPLEX(g == 0)) u_dec (
			.clk(clk),
			.rst(rst),
			.slot_in(slot_in[g]),
			.uop(group.slot[g])
		);
	end

	assign fifo_in_valid = go && (uop_cnt != 0);

	// queue storage, lock and flush
	always_comb begin
		int cnt;
		state_d = state_q;
		mem_d = mem_q;
		head_d = head_q;
		count_d = count_q;
		lock_start_d = lock_start_q;
		loop_len_d = loop_len_q;
		rep_pos_d = rep_pos_q;
		redirect_d = 1'b0;
		cnt = int'(count_q);
		if (mispredict) begin
			state_d = st_normal; // RULE_06
			head_d = '0;
			cnt = 0;
			rep_pos_d = '0;
			redirect_d = 1'b1; // RULE_19
		end else if (state_q == st_replay) begin
			rep_pos_d = loop_off(rep_pos_q, used, loop_len_q); // RULE_05
		end else begin
			if (lock_now) begin
				state_d = st_replay;
				lock_start_d = head_q;
				loop_len_d = mem_q[head_q].loop_len;
				rep_pos_d = '0;
			end
			head_d = q_idx(head_q, used);
			cnt = cnt - used;
			if (pd_in.valid && pd_ready_q) begin
				for (int j = 0; j < PD_MAX; j++) begin
					if (j < int'(pd_in.count)) begin // RULE_18
						mem_d[q_idx(head_q, int'(count_q) + j)] = pd_in.instr[j];
						cnt = cnt + 1;
					end
				end
			end
		end
		count_d = CNT_W'(cnt);
		pd_ready_d = state_d == st_normal && cnt <= DEPTH - PD_MAX; // RULE_01
		fetch_idle_d = state_d == st_replay; // RULE_07
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= st_normal;
			head_q <= '0;
			count_q <= '0;
			lock_start_q <= '0;
			loop_len_q <= '0;
			rep_pos_q <= '0;
			mseq_left_q <= '0;
			mseq_part_q <= '0;
			mseq_instr_q <= '0;
			sp_q <= SP_ZERO;
			pd_ready_q <= 1'b0;
			redirect_q <= 1'b0;
			fetch_idle_q <= 1'b0;
		end else if (ce) begin
			state_q <= state_d;
			head_q <= head_d;
			count_q <= count_d;
			lock_start_q <= lock_start_d;
			loop_len_q <= loop_len_d;
			rep_pos_q <= rep_pos_d;
			mseq_left_q <= mispredict ? '0 : mseq_left_d;
			mseq_part_q <= mseq_part_d;
			mseq_instr_q <= mseq_instr_d;
			sp_q <= mispredict ? SP_ZERO : sp_d;
			pd_ready_q <= pd_ready_d;
			redirect_q <= redirect_d;
			fetch_idle_q <= fetch_idle_d;
		end
	end

	always_ff @(posedge clk) begin
		if (ce)
			mem_q <= mem_d;
	end

	uop_fifo #(.WIDTH($bits(uop_group_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(group),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data(out_group)
	);

	assign pd_ready = pd_ready_q;
	assign redirect = redirect_q;
	assign fetch_idle = fetch_idle_q;
	assign replay_active = fetch_idle_q;

	chk_queue_depth: assert property (@(posedge clk) disable iff (rst) // RULE_01
		count_q <= CNT_W'(DEPTH)) else $error("queue above depth");
	chk_deliver_width: assert property (@(posedge clk) disable iff (rst) // RULE_02
		used <= DELIVER_MAX) else $error("too many instructions delivered");
	chk_one_fusion: assert property (@(posedge clk) disable iff (rst) // RULE_03
		$countones({group.slot[0].macro_fused, group.slot[1].macro_fused,
		group.slot[2].macro_fused, group.slot[3].macro_fused}) <= FUSE_PER_CYCLE)
		else $error("more than one fused pair");
	chk_loop_size: assert property (@(posedge clk) disable iff (rst) // RULE_04
		state_q == st_replay |-> loop_len_q != '0 && int'(loop_len_q) < DEPTH)
		else $error("replayed loop too long");
	chk_lock_hold: assert property (@(posedge clk) disable iff (rst) // RULE_05
		ce && state_q == st_replay && !mispredict
		|=> state_q == st_replay && $stable(head_q) && $stable(count_q))
		else $error("locked loop moved");
	chk_replay_end: assert property (@(posedge clk) disable iff (rst) // RULE_06
		ce && mispredict |=> state_q == st_normal && redirect_q && count_q == '0)
		else $error("misprediction did not end replay");
	chk_fetch_idle: assert property (@(posedge clk) disable iff (rst) // RULE_07
		ce && state_q == st_replay && !mispredict |=> fetch_idle_q && !pd_ready_q)
		else $error("fetch active during replay");
	chk_replay_rate: assert property (@(posedge clk) disable iff (rst) // RULE_08
		go && state_q == st_replay && !mseq_busy |-> used > 0)
		else $error("replay bubble");
	chk_mseq_rate: assert property (@(posedge clk) disable iff (rst) // RULE_11
		mseq_busy |-> uop_cnt <= MSEQ_RATE && used == 0)
		else $error("sequencer over rate");
	chk_no_fuse64: assert property (@(posedge clk) disable iff (rst) // RULE_14
		mode64 |-> fused_cnt == 0) else $error("fusion in 64-bit mode");

endmodule : loop_queue_decode_front_end
`default_nettype wire

// ==== dv/uop_sink.sv ====
/*
 * Drain-side model: takes micro-op bundles, stalls on command.
 * Assumes the bench drives stall at the falling edge.
 */
`timescale 1ns/1ps
`default_nettype none
module uop_sink (
	input wire logic clk,
	input wire logic rst,
	input wire logic stall,
	input wire logic out_valid,
	output logic out_ready
);
	initial out_ready = 1'b0;
	// ready moves only off the sampling edge; low in reset like a real renamer
	always @(negedge clk) begin
		out_ready <= !stall && !rst;
	end
endmodule : uop_sink
`default_nettype wire

// ==== dv/testbench.sv ====
/*
 * Self-checking bench for the loop queue / decode front end.
 * Assumes fe_pkg and the design files are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import fe_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic mode64 = 1'b0;
	logic mispredict = 1'b0;
	logic stall = 1'b0;
	pd_bundle_t pd_in = '0;
	logic pd_ready, redirect, fetch_idle, replay_active, out_valid, out_ready;
	uop_group_t out_group;
	int n_fail = 0;
	int total_checks = 0;
	int nm, nf;
	uop_t got[$];
	instr_t q[$];

	always #5 clk = ~clk;

	loop_queue_decode_front_end i_dut (.clk(clk), .rst(rst), .ce(ce), .mode64(mode64),
		.pd_in(pd_in), .pd_ready(pd_ready), .mispredict(mispredict), .redirect(redirect),
		.fetch_idle(fetch_idle), .replay_active(replay_active), .out_valid(out_valid),
		.out_ready(out_ready), .out_group(out_group));
	uop_sink i_sink (.clk(clk), .rst(rst), .stall(stall), .out_valid(out_valid),
		.out_ready(out_ready));

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : chk

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : results

	task automatic timeout(input string what);
		n_fail++;
		$display("BAD timeout %s", what);
		results();
	endtask : timeout

	// collect taken micro-ops; per-bundle limits checked as they pass
	always @(posedge clk) begin
		if (!rst && ce === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1) begin
			nm = 0;
			nf = 0;
			for (int s = 0; s < NUM_DEC; s++) begin
				if (out_group.slot[s].valid === 1'b1) begin
					got.push_back(out_group.slot[s]);
					nm += int'(out_group.slot[s].from_mseq === 1'b1);
					nf += int'(out_group.slot[s].macro_fused === 1'b1);
				end
			end
			if (nm > MSEQ_RATE) chk("mseq_rate", nm, MSEQ_RATE);
			if (nf > FUSE_PER_CYCLE) chk("fuse_rate", nf, FUSE_PER_CYCLE);
		end
	end

	function automatic instr_t mk(instr_kind_t k, int r, int t);
		instr_t i;
		i = '0;
		i.kind = k;
		i.raw_uops = UOPS_W'(r);
		i.tag = TAG_W'(t);
		return i;
	endfunction : mk

	// hands q to the queue, up to six a cycle, only while pd_ready is high
	task automatic send();
		int k;
		pd_bundle_t b;
		k = 0;
		for (int t = 0; t < 1000 && k < q.size(); t++) begin
			@(negedge clk);
			b = '0;
			if (pd_ready === 1'b1) begin
				b.valid = 1'b1;
				for (int j = 0; j < PD_MAX && k < q.size(); j++) begin
					b.instr[j] = q[k];
					b.count = b.count + 3'h1;
					k++;
				end
			end
			pd_in = b;
		end
		@(negedge clk);
		pd_in = '0;
		if (k < q.size()) timeout("send");
		q.delete();
	endtask : send

	task automatic wait_n(input int n);
		for (int t = 0; t < 500 && got.size() < n; t++) @(negedge clk);
		if (got.size() < n) timeout("uops");
		repeat (10) @(negedge clk);
	endtask : wait_n

	task automatic t_reset();
		repeat (4) @(negedge clk);
		chk("pd_ready_rst", pd_ready, 0);
		chk("out_valid_rst", out_valid, 0);
		chk("idle_rst", {redirect, fetch_idle}, 0);
		@(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		chk("pd_ready_up", pd_ready, 1);
		$display("reset test done");
	endtask : t_reset

	task automatic t_decode();
		q = '{mk(kind_push, 3, 10), mk(kind_pop, 2, 11), mk(kind_subroutine_return_instr, 3, 12),
			mk(kind_cmp, 1, 13), mk(kind_jcc, 1, 14), mk(kind_alu, 2, 15)};
		q[0].sp_delta = -8'sh08;
		q[1].sp_delta = 8'sh08;
		q[5].micro_fusable = 1'b1;
		got.delete();
		send();
		wait_n(5);
		chk("uop_count", got.size(), 5);
		chk("tag_pop", got[1].tag, 11);
		chk("tag_ret", got[2].tag, 12);
		chk("sp_off_pop", {24'h0, got[1].sp_off}, 8'hF8);
		chk("fused_tag", got[3].tag, 14);
		chk("fused_flag", got[3].macro_fused, 1);
		chk("micro_fused", {got[4].tag, 15'h0, got[4].micro_fused}, {16'd15, 16'd1});
		$display("decode test done");
	endtask : t_decode

	task automatic t_fusion_mode();
		for (int m = 1; m >= 0; m--) begin
			mode64 = m[0];
			for (int p = 0; p < 3; p++) q.push_back(mk(kind_cmp, 1, 20 + 2 * p));
			for (int p = 0; p < 3; p++) q.insert(2 * p + 1, mk(kind_jcc, 1, 21 + 2 * p));
			got.delete();
			send();
			wait_n(m ? 6 : 5);
			chk("mode_uops", got.size(), m ? 6 : 5);
			chk("mode_fused", got[0].macro_fused, !m[0]);
			chk("mode_tag", got[0].tag, m ? 20 : 21);
		end
		$display("fusion mode test done");
	endtask : t_fusion_mode

	task automatic t_flows();
		q = '{mk(kind_alu, 4, 30), mk(kind_alu, 7, 31), mk(kind_alu, 1, 32)};
		got.delete();
		send();
		wait_n(12);
		chk("flow_uops", got.size(), 12);
		for (int i = 0; i < 4; i++)
			chk("complex_part", {got[i].tag, got[i].from_mseq, got[i].part}, {16'd30, 1'b0, 3'(i)});
		for (int i = 4; i < 11; i++)
			chk("mseq_uop", {got[i].tag, got[i].from_mseq}, {16'd31, 1'b1});
		chk("after_mseq", got[11].tag, 32);
		$display("flow test done");
	endtask : t_flows

	task automatic t_backpressure();
		for (int i = 0; i < 100; i++) q.push_back(mk(kind_alu, 1, 100 + i));
		got.delete();
		stall = 1'b1;
		fork
			send();
			begin
				repeat (80) @(negedge clk);
				chk("pd_ready_full", pd_ready, 0);
				stall = 1'b0;
			end
		join
		wait_n(100);
		for (int i = 0; i < 100; i++) chk("order", got[i].tag, 100 + i);
		$display("backpressure test done");
	endtask : t_backpressure

	task automatic t_replay();
		int frozen;
		q = '{mk(kind_alu, 1, 40), mk(kind_alu, 1, 41), mk(kind_jcc, 1, 42)};
		q[0].loop_start = 1'b1;
		q[0].loop_len = 5'h03;
		got.delete();
		send();
		for (int t = 0; t < 20 && fetch_idle !== 1'b1; t++) @(negedge clk);
		chk("idle", {fetch_idle, replay_active, pd_ready}, 3'b110);
		wait_n(15);
		for (int i = 0; i < 15; i++) chk("replay_tag", got[i].tag, 40 + i % 3);
		chk("still_idle", fetch_idle, 1);
		ce = 1'b0;
		@(negedge clk);
		frozen = got.size();
		repeat (4) @(negedge clk);
		chk("ce_freeze", got.size(), frozen);
		chk("ce_idle", fetch_idle, 1);
		ce = 1'b1;
		mispredict = 1'b1;
		@(negedge clk);
		mispredict = 1'b0;
		chk("redirect", {redirect, fetch_idle}, 2'b10);
		@(negedge clk);
		chk("resume", {redirect, pd_ready}, 2'b01);
		repeat (40) @(negedge clk);
		got.delete();
		q = '{mk(kind_alu, 1, 50)};
		send();
		wait_n(1);
		chk("after_flush", {got.size() == 1, got[0].tag}, {1'b1, 16'd50});
		$display("replay test done");
	endtask : t_replay

	initial begin
		t_reset();
		t_decode();
		t_fusion_mode();
		t_flows();
		t_backpressure();
		t_replay();
		results();
	end
endmodule : testbench
`default_nettype wire
